// ### core/shl_serial_link.sv
// How it works
// - im2 low selects serial; select picks 3/4-line
// - 3-line packet: flag bit then eight bits
// - 4-line packet: eight bits, flag on pin
// - flag low command; high data or parameter
// - msb first; commands in any order
// - chip select high holds link idle
// - sample data on each rising clock
// - flag taken first edge, or eighth edge
// - next edge after byte starts next packet
// - read command, then answer; host releases select
// - answer bits change on falling clock edges
// - answer lengths 8, 24 or 32 bits
// - hardware reset drops partial byte, expects command
// - select release drops partial byte, resend
// - broken parameter dropped, earlier ones kept
// - cut-in command keeps received parameters only
// - pause after data keeps stream position
// - pause after command allows parameters or command
// - pixel depths 12, 16 and 18 bits
// - write pointer wraps at end of frame
// - only complete pixels are stored
// - format codes 03h, 05h, 06h select depth
`timescale 1ns/1ps
`default_nettype none
module shl_serial_link
  import shl_pkg::*;
#(
  parameter int FRAME_PIXELS = 21384,
  parameter int ADDR_W = 15,
  parameter logic [7:0] MEM_WR_CMD = 8'h2C,
  parameter logic [7:0] RD_ID1_CMD = 8'hDA, // read_ident_byte_one
  parameter logic [7:0] RD_ID2_CMD = 8'hDB, // read_ident_byte_two
  parameter logic [7:0] RD_ID3_CMD = 8'hDC, // read_ident_byte_three
  parameter logic [7:0] RD_DID_CMD = 8'h04, // read_display_ident_cmd
  parameter logic [7:0] RD_DST_CMD = 8'h09  // read_display_status_cmd
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // pins from the host
  input wire logic chip_select_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic cmd_data_flag,
  input wire logic hw_reset_n,
  input wire logic iface_select_bit2,
  input wire logic four_wire_select,
  // serial data output to the host
  output logic sda_out,
  output logic sda_oe_n,
  // received bytes to the decoder
  output logic byte_valid,
  output shl_byte_t byte_out,
  // pixels to frame memory
  output logic pixel_valid,
  output shl_pixel_t pixel_out,
  output logic [ADDR_W-1:0] pixel_addr,
  output logic [2:0] pixel_format,
  // read-back words from the register source
  output logic rd_req,
  output logic [7:0] rd_cmd,
  input wire logic [31:0] rd_data
);

  // refuse sizes the wrap compare cannot serve; the shift overflows past 30 bits
  if (ADDR_W < 1 || ADDR_W > 30 || FRAME_PIXELS < 2 ||
      FRAME_PIXELS > (1 << ADDR_W)) begin : g_bad_size
    $error("frame size does not fit the pixel address width");
  end

  localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(FRAME_PIXELS - 1);
  localparam logic [ADDR_W-1:0] ADDR_ZERO = '0;

  // answer length of a command, none for anything that is not a read
  function automatic logic [5:0] rd_len(input logic [7:0] c);
    if (c == RD_ID1_CMD || c == RD_ID2_CMD || c == RD_ID3_CMD) begin
      rd_len = RD_LEN_8;
    end else if (c >= STATUS_FIRST && c <= STATUS_LAST) begin
      rd_len = RD_LEN_8;
    end else if (c == RD_DID_CMD) begin
      rd_len = RD_LEN_24;
    end else if (c == RD_DST_CMD) begin
      rd_len = RD_LEN_32;
    end else begin
      rd_len = RD_LEN_NONE;
    end
  endfunction

  // widen a narrow channel to six bits, msb aligned
  function automatic logic [5:0] pad4(input logic [3:0] v);
    pad4 = {v, 2'h0};
  endfunction

  // ==========================================================================
  // pin synchroniser: three stages, a change counts when stages two and three agree
  logic [6:0] sync1, sync2, sync3, filt;
  logic [6:0] next_filt;
  logic [6:0] pins;
  logic scl_rise, scl_fall, cs_f, hrst_f, serial_sel;

  assign pins = {four_wire_select, iface_select_bit2, hw_reset_n, cmd_data_flag,
                 sda_in, scl, chip_select_n};

  // next filtered level per pin
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_filt[i] = (sync2[i] == sync3[i]) ? sync3[i] : filt[i];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      sync3 <= PIN_IDLE;
      filt <= PIN_IDLE;
    end else if (clk_en) begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end

  assign scl_rise = next_filt[PIN_SCL] && !filt[PIN_SCL];
  assign scl_fall = !next_filt[PIN_SCL] && filt[PIN_SCL];
  assign cs_f = filt[PIN_CS];
  assign hrst_f = filt[PIN_HRST];
  assign serial_sel = (filt[PIN_IM2] == IFACE_SERIAL);

  // ==========================================================================
  // receive, decode and pixel assembly
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic flag_bit, next_flag_bit;
  logic [7:0] cur_cmd, next_cur_cmd;
  logic [3:0] pidx, next_pidx;
  logic in_mem, next_in_mem;
  logic [1:0] phase, next_phase;
  logic [7:0] hold_hi, next_hold_hi;
  logic [7:0] hold_lo, next_hold_lo;
  logic [ADDR_W-1:0] wr_addr, next_wr_addr;
  logic [2:0] next_pixel_format;
  logic rd_mode, next_rd_mode;
  logic next_byte_valid, next_pixel_valid, next_rd_req;
  shl_byte_t next_byte_out;
  shl_pixel_t next_pixel_out;
  logic [ADDR_W-1:0] next_pixel_addr;
  logic [7:0] next_rd_cmd;
  logic rx_on, done, flag_now;
  logic [7:0] data_now;

  // link listens only when selected, released by select, out of reset, not answering
  assign rx_on = serial_sel && !cs_f && hrst_f && !rd_mode;

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_flag_bit = flag_bit;
    next_cur_cmd = cur_cmd;
    next_pidx = pidx;
    next_in_mem = in_mem;
    next_phase = phase;
    next_hold_hi = hold_hi;
    next_hold_lo = hold_lo;
    next_wr_addr = wr_addr;
    next_pixel_format = pixel_format;
    next_rd_mode = rd_mode;
    next_byte_valid = 1'b0;
    next_byte_out = byte_out;
    next_pixel_valid = 1'b0;
    next_pixel_out = pixel_out;
    next_pixel_addr = pixel_addr;
    next_rd_req = 1'b0;
    next_rd_cmd = rd_cmd;
    done = 1'b0;
    flag_now = flag_bit;
    data_now = {shreg[6:0], filt[PIN_SDA]};
    if (!hrst_f) begin
      // drop partial bits and expect a command next
      next_bit_cnt = CNT_ZERO;
      next_cur_cmd = NOP_CMD;
      next_pidx = '0;
      next_in_mem = 1'b0;
      next_phase = PHASE_0;
      next_rd_mode = 1'b0;
    end else if (cs_f || !serial_sel) begin
      // partial byte dropped, stream position kept for the resend or pause
      next_bit_cnt = CNT_ZERO;
      next_rd_mode = 1'b0;
    end else if (rx_on && scl_rise) begin
      if (!filt[PIN_4W]) begin
        // 3-line: first edge is the flag, then eight data bits
        if (bit_cnt == CNT_ZERO) begin
          next_flag_bit = filt[PIN_SDA];
        end else begin
          next_shreg = data_now;
        end
        if (bit_cnt == CNT_LAST3) begin
          done = 1'b1;
          next_bit_cnt = CNT_ZERO;
        end else begin
          next_bit_cnt = bit_cnt + 4'h1;
        end
      end else begin
        // 4-line: flag pin is taken together with the eighth bit
        next_shreg = data_now;
        if (bit_cnt == CNT_LAST4) begin
          done = 1'b1;
          flag_now = filt[PIN_DCX];
          next_flag_bit = flag_now;
          next_bit_cnt = CNT_ZERO;
        end else begin
          next_bit_cnt = bit_cnt + 4'h1;
        end
      end
    end
    // only whole bytes ever leave the link, so a broken one never lands
    if (done) begin
      next_byte_valid = 1'b1;
      next_byte_out = '{flag: flag_now, data: data_now, pidx: pidx};
      if (flag_now == FLAG_CMD) begin
        // a new command restarts parameter count and drops any partial pixel
        next_cur_cmd = data_now;
        next_pidx = '0;
        next_phase = PHASE_0;
        next_in_mem = (data_now == MEM_WR_CMD);
        if (data_now == MEM_WR_CMD) begin
          next_wr_addr = ADDR_ZERO;
        end
        if (rd_len(data_now) != RD_LEN_NONE) begin
          next_rd_mode = 1'b1;
          next_rd_req = 1'b1;
          next_rd_cmd = data_now;
        end
      end else if (in_mem) begin
        // pixel assembly by depth; emit only when a pixel completes
        next_phase = phase + 2'h1;
        unique case (pixel_format)
          FMT_12: begin
            if (phase == PHASE_0) begin
              next_hold_hi = data_now;
            end else if (phase == PHASE_1) begin
              next_hold_lo = data_now;
              next_pixel_valid = 1'b1;
              next_pixel_out = '{red: pad4(hold_hi[7:4]), green: pad4(hold_hi[3:0]),
                                 blue: pad4(data_now[7:4])};
            end else begin
              next_phase = PHASE_0;
              next_pixel_valid = 1'b1;
              next_pixel_out = '{red: pad4(hold_lo[3:0]), green: pad4(data_now[7:4]),
                                 blue: pad4(data_now[3:0])};
            end
          end
          FMT_16: begin
            if (phase == PHASE_0) begin
              next_hold_hi = data_now;
            end else begin
              next_phase = PHASE_0;
              next_pixel_valid = 1'b1;
              next_pixel_out = '{red: {hold_hi[7:3], 1'b0},
                                 green: {hold_hi[2:0], data_now[7:5]},
                                 blue: {data_now[4:0], 1'b0}};
            end
          end
          default: begin
            // 18-bit: six upper bits of each of three bytes
            if (phase == PHASE_0) begin
              next_hold_hi = data_now;
            end else if (phase == PHASE_1) begin
              next_hold_lo = data_now;
            end else begin
              next_phase = PHASE_0;
              next_pixel_valid = 1'b1;
              next_pixel_out = '{red: hold_hi[7:2], green: hold_lo[7:2],
                                 blue: data_now[7:2]};
            end
          end
        endcase
        if (next_pixel_valid) begin
          next_pixel_addr = wr_addr;
          next_wr_addr = (wr_addr == ADDR_LAST) ? ADDR_ZERO : wr_addr + 1'b1;
        end
      end else begin
        // parameter byte: count it, and latch the depth code when it is one
        if (pidx != PIDX_MAX) begin
          next_pidx = pidx + 4'h1;
        end
        if (cur_cmd == PIXFMT_CMD && pidx == '0 &&
            (data_now[2:0] == FMT_12 || data_now[2:0] == FMT_16 ||
             data_now[2:0] == FMT_18)) begin
          next_pixel_format = data_now[2:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt <= CNT_ZERO;
      shreg <= 8'h00;
      flag_bit <= 1'b0;
      cur_cmd <= NOP_CMD;
      pidx <= '0;
      in_mem <= 1'b0;
      phase <= PHASE_0;
      hold_hi <= 8'h00;
      hold_lo <= 8'h00;
      wr_addr <= ADDR_ZERO;
      pixel_format <= FMT_RESET;
      rd_mode <= 1'b0;
      byte_valid <= 1'b0;
      byte_out <= '0;
      pixel_valid <= 1'b0;
      pixel_out <= '0;
      pixel_addr <= ADDR_ZERO;
      rd_req <= 1'b0;
      rd_cmd <= NOP_CMD;
    end else if (clk_en) begin
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      flag_bit <= next_flag_bit;
      cur_cmd <= next_cur_cmd;
      pidx <= next_pidx;
      in_mem <= next_in_mem;
      phase <= next_phase;
      hold_hi <= next_hold_hi;
      hold_lo <= next_hold_lo;
      wr_addr <= next_wr_addr;
      pixel_format <= next_pixel_format;
      rd_mode <= next_rd_mode;
      byte_valid <= next_byte_valid;
      byte_out <= next_byte_out;
      pixel_valid <= next_pixel_valid;
      pixel_out <= next_pixel_out;
      pixel_addr <= next_pixel_addr;
      rd_req <= next_rd_req;
      rd_cmd <= next_rd_cmd;
    end
  end

  // ==========================================================================
  // read-back shifter; the word is loaded one cycle after the request
  logic [31:0] tx_sh, next_tx_sh;
  logic [5:0] tx_left, next_tx_left;
  logic next_sda_out, next_sda_oe_n;

  always_comb begin
    next_tx_sh = tx_sh;
    next_tx_left = tx_left;
    next_sda_out = sda_out;
    next_sda_oe_n = sda_oe_n;
    if (!rd_mode) begin
      next_tx_left = RD_LEN_NONE;
      next_sda_oe_n = 1'b1;
    end else if (rd_req) begin
      // msb-align the answer so bit 31 always goes out first
      next_tx_sh = rd_data << (RD_WORD_BITS - rd_len(rd_cmd));
      next_tx_left = rd_len(rd_cmd);
    end else if (scl_fall) begin
      // the last bit is held until the falling edge after it
      if (tx_left != RD_LEN_NONE) begin
        next_sda_out = tx_sh[31];
        next_tx_sh = {tx_sh[30:0], 1'b0};
        next_tx_left = tx_left - 6'h01;
        next_sda_oe_n = 1'b0;
      end else begin
        next_sda_oe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sh <= 32'h00000000;
      tx_left <= RD_LEN_NONE;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (clk_en) begin
      tx_sh <= next_tx_sh;
      tx_left <= next_tx_left;
      sda_out <= next_sda_out;
      sda_oe_n <= next_sda_oe_n;
    end
  end

  // ==========================================================================
  // assertions
  property p_cs_idle;
    @(posedge ref_clk) disable iff (!reset_n || !clk_en)
      cs_f |=> bit_cnt == CNT_ZERO && !byte_valid;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("link not idle under select high");

  property p_byte_on_rise;
    @(posedge ref_clk) disable iff (!reset_n || !clk_en)
      byte_valid |-> $past(scl_rise) && $past(rx_on);
  endproperty
  a_byte_on_rise: assert property (p_byte_on_rise) else $error("byte without rising clock");

  property p_hrst_clear;
    @(posedge ref_clk) disable iff (!reset_n || !clk_en)
      !hrst_f |=> !in_mem && pidx == '0 && bit_cnt == CNT_ZERO && cur_cmd == NOP_CMD;
  endproperty
  a_hrst_clear: assert property (p_hrst_clear) else $error("hardware reset left state");

  property p_cs_break;
    @(posedge ref_clk) disable iff (!reset_n || !clk_en)
      $rose(cs_f) && bit_cnt != CNT_ZERO |=> bit_cnt == CNT_ZERO ##1 !byte_valid;
  endproperty
  a_cs_break: assert property (p_cs_break) else $error("partial byte survived release");

  property p_cmd_restart;
    @(posedge ref_clk) disable iff (!reset_n || !clk_en)
      byte_valid && byte_out.flag == FLAG_CMD |-> pidx == '0 && phase == PHASE_0;
  endproperty
  a_cmd_restart: assert property (p_cmd_restart) else $error("command kept old stream");

  property p_rd_len32;
    @(posedge ref_clk) disable iff (!reset_n || !clk_en)
      rd_req && rd_cmd == RD_DST_CMD && rd_mode |=> tx_left == RD_LEN_32;
  endproperty
  a_rd_len32: assert property (p_rd_len32) else $error("status read not 32 bits");

  property p_out_on_fall;
    @(posedge ref_clk) disable iff (!reset_n || !clk_en)
      $fell(sda_oe_n) || (!sda_oe_n && $changed(sda_out)) |-> $past(scl_fall);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off falling edge");

  property p_wrap;
    @(posedge ref_clk) disable iff (!reset_n || !clk_en)
      pixel_valid && pixel_addr == ADDR_LAST && in_mem |-> wr_addr == ADDR_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("write pointer did not wrap");

  property p_pixel_mem;
    @(posedge ref_clk) disable iff (!reset_n || !clk_en)
      pixel_valid |-> byte_valid && byte_out.flag != FLAG_CMD && $past(in_mem);
  endproperty
  a_pixel_mem: assert property (p_pixel_mem) else $error("pixel outside memory write");

  c_cmd_byte: cover property (@(posedge ref_clk) disable iff (!reset_n)
    byte_valid && byte_out.flag == FLAG_CMD);
  c_pixel: cover property (@(posedge ref_clk) disable iff (!reset_n) pixel_valid);
  c_read: cover property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(sda_oe_n) ##[1:400] $rose(sda_oe_n));
  c_wrap: cover property (@(posedge ref_clk) disable iff (!reset_n)
    pixel_valid && pixel_addr == ADDR_LAST);

endmodule
`default_nettype wire

// ### core/shl_pkg.sv
// ==========================================================================
// shared types and constants of the serial host link
package shl_pkg;

  // synchronised pin vector layout
  localparam int PIN_CS = 0;
  localparam int PIN_SCL = 1;
  localparam int PIN_SDA = 2;
  localparam int PIN_DCX = 3;
  localparam int PIN_HRST = 4;
  localparam int PIN_IM2 = 5;
  localparam int PIN_4W = 6;
  localparam int PIN_COUNT = 7;
  // idle levels: chip select and hardware reset high, the rest low
  localparam logic [6:0] PIN_IDLE = 7'h11;

  // ==========================================================================
  // framing
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_LAST3 = 4'h8; // flag bit plus eight data bits
  localparam logic [3:0] CNT_LAST4 = 4'h7; // eight data bits
  localparam logic IFACE_SERIAL = 1'b0;
  localparam logic FLAG_CMD = 1'b0;

  // ==========================================================================
  // commands and pixel formats
  localparam logic [7:0] PIXFMT_CMD = 8'h3A;
  localparam logic [7:0] STATUS_FIRST = 8'h0A;
  localparam logic [7:0] STATUS_LAST = 8'h0F;
  localparam logic [7:0] NOP_CMD = 8'h00;
  localparam logic [2:0] FMT_12 = 3'h3;
  localparam logic [2:0] FMT_16 = 3'h5;
  localparam logic [2:0] FMT_18 = 3'h6;
  localparam logic [2:0] FMT_RESET = 3'h6;

  // read-back lengths in bits
  localparam logic [5:0] RD_LEN_8 = 6'h08;
  localparam logic [5:0] RD_LEN_24 = 6'h18;
  localparam logic [5:0] RD_LEN_32 = 6'h20;
  localparam logic [5:0] RD_LEN_NONE = 6'h00;
  localparam logic [5:0] RD_WORD_BITS = 6'h20;

  localparam logic [1:0] PHASE_0 = 2'h0;
  localparam logic [1:0] PHASE_1 = 2'h1;
  localparam logic [1:0] PHASE_2 = 2'h2;
  localparam logic [3:0] PIDX_MAX = 4'hF;

  // one received byte for the command decoder
  typedef struct packed {
    logic flag;
    logic [7:0] data;
    logic [3:0] pidx;
  } shl_byte_t;

  // one complete pixel, each channel msb-aligned in six bits
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } shl_pixel_t;

endpackage

// ### tb/shl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module shl_host_model (
  // clock and link mode
  input wire logic ref_clk,
  input wire logic four_wire_select,
  // resolved data line
  input wire logic sda_line,
  // pins driven toward the device
  output logic chip_select_n,
  output logic scl,
  output logic sda_bit,
  output logic host_oe,
  output logic cmd_data_flag
);
  // ==========================================================================
  // idle pins: select high, clock starts low and rests where the last bit left it
  initial begin
    chip_select_n = 1'h1;
    scl = 1'h0;
    sda_bit = 1'h0;
    host_oe = 1'h1;
    cmd_data_flag = 1'h0;
  end

  // data set up in the low phase and held over the rise
  task automatic bitx(input logic b);
    scl = 1'h0;
    sda_bit = b;
    repeat (4) @(negedge ref_clk);
    scl = 1'h1;
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic cs(input logic v);
    chip_select_n = v;
    repeat (4) @(negedge ref_clk);
  endtask

  // nb below eight cuts the byte short to break a transfer
  task automatic send(input logic flag, input logic [7:0] b, input int nb = 8);
    cmd_data_flag = flag;
    if (!four_wire_select) begin
      bitx(flag);
    end
    for (int i = 7; i > 7 - nb; i--) begin
      bitx(b[i]);
    end
  endtask

  // answer: let go of the line at once; take each bit late in the
  // high phase, as the device moves it only a few cycles after the fall
  task automatic get(input int n, output logic [31:0] w);
    w = 32'h0;
    host_oe = 1'h0;
    for (int i = 0; i < n; i++) begin
      scl = 1'h0;
      repeat (4) @(negedge ref_clk);
      scl = 1'h1;
      repeat (3) @(negedge ref_clk);
      w = {w[30:0], sda_line};
      @(negedge ref_clk);
    end
    scl = 1'h0;
    cs(1'h1);
    host_oe = 1'h1;
  endtask
endmodule
`default_nettype wire

// ### tb/shl_serial_link_tb.sv
`timescale 1ns/1ps
`default_nettype none
module shl_serial_link_tb
  import shl_pkg::*;
;
  logic ref_clk, reset_n, hw_reset_n, iface_select_bit2, four_wire_select;
  logic chip_select_n, scl, sda_bit, host_oe, cmd_data_flag, sda_w;
  logic noise = 1'h0;
  logic clk_en;
  logic sda_out, sda_oe_n, byte_valid, pixel_valid, rd_req;
  shl_byte_t byte_out;
  shl_pixel_t pixel_out;
  logic [3:0] pixel_addr;
  logic [2:0] pixel_format;
  logic [7:0] rd_cmd;
  logic [31:0] rd_data;
  int num_errors = 0;
  int n_compared = 0;
  int n_req = 0;
  shl_byte_t bq[$];
  shl_pixel_t pq[$];
  logic [3:0] aq[$];

  // ==========================================================================
  // clock, wire resolution and register source
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  // a released line must not keep a stale level, so it flips each cycle
  always @(negedge ref_clk) noise <= ~noise;
  assign sda_w = !sda_oe_n ? sda_out : (host_oe ? sda_bit : noise);
  function automatic logic [31:0] word(input logic [7:0] c);
    word = {c, 8'hC3, ~c, 8'h96};
  endfunction
  assign rd_data = word(rd_cmd);

  // small frame so the write address wraps within a short run
  shl_serial_link #(.FRAME_PIXELS(4), .ADDR_W(4)) i_shl_serial_link (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .chip_select_n(chip_select_n), .scl(scl), .sda_in(sda_w),
    .cmd_data_flag(cmd_data_flag), .hw_reset_n(hw_reset_n),
    .iface_select_bit2(iface_select_bit2), .four_wire_select(four_wire_select),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .byte_valid(byte_valid), .byte_out(byte_out),
    .pixel_valid(pixel_valid), .pixel_out(pixel_out), .pixel_addr(pixel_addr),
    .pixel_format(pixel_format), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_data(rd_data));
  shl_host_model i_shl_host_model (
    .ref_clk(ref_clk), .four_wire_select(four_wire_select), .sda_line(sda_w),
    .chip_select_n(chip_select_n), .scl(scl), .sda_bit(sda_bit), .host_oe(host_oe),
    .cmd_data_flag(cmd_data_flag));

  // collect every byte, pixel and read request, mid-cycle where they have settled
  always @(negedge ref_clk) begin
    if (byte_valid === 1'h1) bq.push_back(byte_out);
    if (rd_req === 1'h1) n_req++;
    if (pixel_valid === 1'h1) begin
      pq.push_back(pixel_out);
      aq.push_back(pixel_addr);
    end
  end

  // ==========================================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // parameter index only matters for flagged bytes
  task automatic cb(input logic f, input logic [7:0] d, input logic [3:0] p);
    shl_byte_t b;
    b = 'x;
    if (bq.size() > 0) b = bq.pop_front();
    chk({b.flag, b.data, f ? b.pidx : 4'h0}, {f, d, f ? p : 4'h0});
  endtask
  task automatic tx(input logic f, input logic [7:0] b, input int nb = 8);
    i_shl_host_model.send(f, b, nb);
  endtask
  task automatic sel(input logic v);
    i_shl_host_model.cs(v);
  endtask
  task automatic settle;
    repeat (8) @(negedge ref_clk);
  endtask
  function automatic logic [7:0] dat(input int k);
    dat = 8'(k * 29 + 53);
  endfunction
  function automatic shl_pixel_t pix(input logic [2:0] fc, input int j);
    logic [7:0] a, b, c;
    int g;
    g = (fc == FMT_12) ? j / 2 * 3 : ((fc == FMT_16) ? j * 2 : j * 3);
    a = dat(g);
    b = dat(g + 1);
    c = dat(g + 2);
    if (fc == FMT_18) pix = {a[7:2], b[7:2], c[7:2]};
    else if (fc == FMT_16) pix = {a[7:3], 1'h0, a[2:0], b[7:5], b[4:0], 1'h0};
    else if (j % 2 == 0) pix = {a[7:4], 2'h0, a[3:0], 2'h0, b[7:4], 2'h0};
    else pix = {b[3:0], 2'h0, c[7:4], 2'h0, c[3:0], 2'h0};
  endfunction

  // ==========================================================================
  // scenarios
  task automatic t_write(input logic m);
    four_wire_select = m;
    sel(1'h0);
    tx(1'h0, 8'hB1);
    tx(1'h1, 8'h81);
    tx(1'h1, 8'h7E);
    tx(1'h0, 8'h2A);
    sel(1'h1);
    settle();
    cb(1'h0, 8'hB1, 4'h0);
    cb(1'h1, 8'h81, 4'h0);
    cb(1'h1, 8'h7E, 4'h1);
    cb(1'h0, 8'h2A, 4'h0);
    chk(bq.size(), 0);
    $display("write test done, four-wire %0d", m);
  endtask

  task automatic t_break;
    tx(1'h1, 8'hFF);
    sel(1'h0);
    tx(1'h0, 8'hC5);
    tx(1'h1, 8'h12);
    sel(1'h1);
    sel(1'h0);
    tx(1'h1, 8'h34, 4);
    sel(1'h1);
    sel(1'h0);
    tx(1'h1, 8'h34);
    sel(1'h1);
    sel(1'h0);
    tx(1'h0, 8'hC6);
    sel(1'h1);
    sel(1'h0);
    tx(1'h1, 8'h56);
    tx(1'h1, 8'h78, 5);
    sel(1'h1);
    sel(1'h0);
    tx(1'h0, 8'hC7);
    tx(1'h1, 8'h9A);
    tx(1'h0, 8'hC8);
    sel(1'h1);
    settle();
    cb(1'h0, 8'hC5, 4'h0);
    cb(1'h1, 8'h12, 4'h0);
    cb(1'h1, 8'h34, 4'h1);
    cb(1'h0, 8'hC6, 4'h0);
    cb(1'h1, 8'h56, 4'h0);
    cb(1'h0, 8'hC7, 4'h0);
    cb(1'h1, 8'h9A, 4'h0);
    cb(1'h0, 8'hC8, 4'h0);
    chk(bq.size(), 0);
    $display("break and pause test done");
  endtask

  task automatic t_hw;
    sel(1'h0);
    tx(1'h0, 8'hCA);
    tx(1'h1, 8'h11);
    tx(1'h1, 8'h22, 3);
    hw_reset_n = 1'h0;
    settle();
    hw_reset_n = 1'h1;
    settle();
    sel(1'h1);
    sel(1'h0);
    tx(1'h1, 8'h33);
    sel(1'h1);
    settle();
    cb(1'h0, 8'hCA, 4'h0);
    cb(1'h1, 8'h11, 4'h0);
    cb(1'h1, 8'h33, 4'h0);
    chk(bq.size(), 0);
    $display("hardware reset test done");
  endtask

  task automatic t_read;
    logic [7:0] rc[7];
    int rn[7];
    logic [31:0] w;
    rc = '{8'hDA, 8'hDB, 8'hDC, 8'h04, 8'h09, 8'h0A, 8'h0F};
    rn = '{8, 8, 8, 24, 32, 8, 8};
    for (int i = 0; i < 7; i++) begin
      four_wire_select = i[0];
      sel(1'h0);
      tx(1'h0, rc[i]);
      i_shl_host_model.get(rn[i], w);
      settle();
      chk(w, word(rc[i]) << (32 - rn[i]) >> (32 - rn[i]));
      chk(sda_oe_n, 1'h1);
      cb(1'h0, rc[i], 4'h0);
      chk(n_req, i + 1);
      chk(rd_cmd, rc[i]);
    end
    $display("read test done");
  endtask

  task automatic t_pixel;
    logic [2:0] fc[3];
    int n;
    fc = '{FMT_12, FMT_16, FMT_18};
    for (int f = 0; f < 3; f++) begin
      four_wire_select = f[0];
      sel(1'h0);
      tx(1'h0, PIXFMT_CMD);
      tx(1'h1, {5'h00, fc[f]});
      tx(1'h0, 8'h2C); // memory write with the default code
      for (int k = 0; k < 13; k++) tx(1'h1, dat(k));
      tx(1'h0, NOP_CMD);
      sel(1'h1);
      settle();
      n = (fc[f] == FMT_16) ? 6 : ((fc[f] == FMT_12) ? 8 : 4);
      chk(pixel_format, fc[f]);
      chk(pq.size(), n);
      for (int j = 0; j < n && pq.size() > 0; j++) begin
        chk(pq.pop_front(), pix(fc[f], j));
        chk(aq.pop_front(), j % 4);
      end
      pq.delete();
      aq.delete();
    end
    bq.delete();
    $display("pixel test done");
  endtask

  task automatic t_iface;
    iface_select_bit2 = 1'h1;
    sel(1'h0);
    tx(1'h0, 8'hEE);
    sel(1'h1);
    settle();
    chk(bq.size(), 0);
    iface_select_bit2 = 1'h0;
    // enable low freezes the synchronisers too, so a whole byte goes unseen
    clk_en = 1'h0;
    sel(1'h0);
    tx(1'h0, 8'hEF);
    sel(1'h1);
    clk_en = 1'h1;
    settle();
    chk(bq.size(), 0);
    $display("interface select test done");
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // hang guard: running out counts as a mismatch
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    close_out();
  end

  // main sequence
  initial begin
    reset_n = 1'h0;
    clk_en = 1'h1;
    hw_reset_n = 1'h1;
    iface_select_bit2 = 1'h0;
    four_wire_select = 1'h0;
    repeat (6) @(negedge ref_clk);
    reset_n = 1'h1;
    repeat (4) @(negedge ref_clk);
    t_write(1'h0);
    t_write(1'h1);
    t_break();
    t_hw();
    t_read();
    t_pixel();
    t_iface();
    close_out();
  end
endmodule
`default_nettype wire
